// file: wer_pkg.sv
package wer_pkg;

    // Register offsets on the host register port
    localparam logic [7:0] OFS_MISC_STATUS = 8'h00;
    localparam logic [7:0] OFS_GP_STATUS = 8'h01;
    localparam logic [7:0] OFS_MISC_ENABLE = 8'h02;
    localparam logic [7:0] OFS_GP_ENABLE = 8'h03;
    localparam logic [7:0] OFS_CONFIG = 8'h04;
    localparam logic [7:0] OFS_IRQ_MASK_MISC = 8'h05;
    localparam logic [7:0] OFS_IRQ_MASK_GP = 8'h06;
    localparam logic [7:0] OFS_ROUTE_MISC = 8'h13;
    localparam logic [7:0] OFS_ROUTE_GP = 8'h14;

    // Reset values
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [7:0] RST_RDATA = 8'h00;

    // Field layout of the configuration register
    localparam int CFG_BANK_LSB = 0;
    localparam int CFG_BANK_MSB = 1;
    localparam int CFG_SWAP_BIT = 2;
    localparam logic [7:0] CFG_WRITABLE = 8'h07;

    // Misc routing register: bits 7 and 5 are reserved
    localparam logic [7:0] ROUTE_MISC_WRITABLE = 8'h5F;

    // Event bit shared by wake input 4 and the ring event
    localparam int GP_SHARED_BIT = 4;

    typedef enum logic [1:0] {
        BANK_KBD_MOUSE,
        BANK_CONSUMER_IR,
        BANK_EVENT_ROUTING,
        BANK_STANDBY_GPIO
    } wer_bank_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } wer_bus_req_s;

    typedef struct packed {
        logic clk;
        logic data;
    } wer_ps2_s;

endpackage : wer_pkg

// file: wer_sticky_bits.sv
`timescale 1ns/1ns
`default_nettype none

module wer_sticky_bits #(
    parameter int WIDTH = 8
) (
    input wire logic clk,                // System clock
    input wire logic arst_n,             // Async reset, active low
    input wire logic ce,                 // Clock enable
    input wire logic clr_all,            // Synchronous clear of all bits
    input wire logic [WIDTH-1:0] set,    // Event pulses
    input wire logic [WIDTH-1:0] w1c,    // Write-one-to-clear mask
    output logic [WIDTH-1:0] q           // Sticky status
);

    logic [WIDTH-1:0] next_q;

    // Per bit: a set in the same cycle as a clear wins
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_comb begin
            if (set[i]) begin
                next_q[i] = 1'b1;
            end else if (clr_all || w1c[i]) begin
                next_q[i] = 1'b0;
            end else begin
                next_q[i] = q[i];
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= next_q;
        end
    end

endmodule : wer_sticky_bits

`default_nettype wire

// file: wer_top.sv
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none

module wer_top #(
    parameter int EVENTS = 8
) (
    input wire logic clk,                        // 10 MHz clock
    input wire logic arst_n,                     // Power-up reset, active low
    input wire logic ce,                         // Clock enable
    input wire logic soft_reset,                 // Software reset pulse
    input wire wer_pkg::wer_bus_req_s bus,       // Register request
    output logic [7:0] rd_data,                  // Read data, next cycle
    input wire logic [EVENTS-1:0] misc_event_in, // Misc detected events
    input wire logic [EVENTS-1:0] gp_wake_in,    // Wake input events
    input wire logic ring_event_in,              // Ring event on shared pin
    input wire logic ring_select,                // Shared pin carries ring
    input wire wer_pkg::wer_ps2_s kbd_in,        // Keyboard clock/data in
    input wire wer_pkg::wer_ps2_s mouse_in,      // Mouse clock/data in
    output wer_pkg::wer_ps2_s kbc_kbd,           // To keyboard port logic
    output wer_pkg::wer_ps2_s kbc_mouse,         // To mouse port logic
    output logic power_wakeup_request_n,         // Wake request, active low
    output logic management_interrupt_n,         // Mgmt interrupt, act. low
    output logic irq                             // Status interrupt, high
);

    logic [7:0] misc_wake_event_enable;
    logic [7:0] gp_wake_event_enable;
    logic [7:0] wake_config_bank_select;
    logic [7:0] misc_event_to_mgmt_int_route;
    logic [7:0] gp_event_to_mgmt_int_route;
    logic [7:0] irq_mask_misc;
    logic [7:0] irq_mask_gp;
    logic [7:0] next_misc_wake_event_enable;
    logic [7:0] next_gp_wake_event_enable;
    logic [7:0] next_wake_config_bank_select;
    logic [7:0] next_misc_event_to_mgmt_int_route;
    logic [7:0] next_gp_event_to_mgmt_int_route;
    logic [7:0] next_irq_mask_misc;
    logic [7:0] next_irq_mask_gp;

    logic [EVENTS-1:0] misc_status;
    logic [EVENTS-1:0] gp_status;
    logic [EVENTS-1:0] gp_set;
    logic [EVENTS-1:0] misc_w1c;
    logic [EVENTS-1:0] gp_w1c;
    logic routing_bank;
    wer_pkg::wer_bank_e bank;

    logic [7:0] next_rd_data;
    logic next_wakeup_n;
    logic next_mgmt_n;
    logic next_irq;
    wer_pkg::wer_ps2_s next_kbc_kbd;
    wer_pkg::wer_ps2_s next_kbc_mouse;

    assign bank = wer_pkg::wer_bank_e'(
        wake_config_bank_select[wer_pkg::CFG_BANK_MSB:wer_pkg::CFG_BANK_LSB]);
    assign routing_bank = (bank == wer_pkg::BANK_EVENT_ROUTING);

    // Shared pin: bit 4 takes whichever source is selected
    always_comb begin
        gp_set = gp_wake_in;
        gp_set[wer_pkg::GP_SHARED_BIT] = ring_select ? ring_event_in
            : gp_wake_in[wer_pkg::GP_SHARED_BIT];
    end

    always_comb begin
        misc_w1c = '0;
        gp_w1c = '0;
        if (bus.wr && bus.addr == wer_pkg::OFS_MISC_STATUS) begin
            misc_w1c = bus.wdata[EVENTS-1:0];
        end
        if (bus.wr && bus.addr == wer_pkg::OFS_GP_STATUS) begin
            gp_w1c = bus.wdata[EVENTS-1:0];
        end
    end

    wer_sticky_bits #(.WIDTH(EVENTS)) u_misc_status (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .clr_all(soft_reset),
        .set(misc_event_in),
        .w1c(misc_w1c),
        .q(misc_status)
    );

    wer_sticky_bits #(.WIDTH(EVENTS)) u_gp_status (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .clr_all(soft_reset),
        .set(gp_set),
        .w1c(gp_w1c),
        .q(gp_status)
    );

    // Control registers
    always_comb begin
        next_misc_wake_event_enable = misc_wake_event_enable;
        next_gp_wake_event_enable = gp_wake_event_enable;
        next_wake_config_bank_select = wake_config_bank_select;
        next_misc_event_to_mgmt_int_route = misc_event_to_mgmt_int_route;
        next_gp_event_to_mgmt_int_route = gp_event_to_mgmt_int_route;
        next_irq_mask_misc = irq_mask_misc;
        next_irq_mask_gp = irq_mask_gp;
        if (soft_reset) begin
            next_misc_wake_event_enable = wer_pkg::RST_REG;
            next_gp_wake_event_enable = wer_pkg::RST_REG;
            next_wake_config_bank_select = wer_pkg::RST_REG;
            next_misc_event_to_mgmt_int_route = wer_pkg::RST_REG;
            next_gp_event_to_mgmt_int_route = wer_pkg::RST_REG;
            next_irq_mask_misc = wer_pkg::RST_REG;
            next_irq_mask_gp = wer_pkg::RST_REG;
        end else if (bus.wr) begin
            case (bus.addr)
                wer_pkg::OFS_MISC_ENABLE: begin
                    next_misc_wake_event_enable = bus.wdata;
                end
                wer_pkg::OFS_GP_ENABLE: begin
                    next_gp_wake_event_enable = bus.wdata;
                end
                wer_pkg::OFS_CONFIG: begin
                    next_wake_config_bank_select =
                        bus.wdata & wer_pkg::CFG_WRITABLE;
                end
                wer_pkg::OFS_IRQ_MASK_MISC: begin
                    next_irq_mask_misc = bus.wdata;
                end
                wer_pkg::OFS_IRQ_MASK_GP: begin
                    next_irq_mask_gp = bus.wdata;
                end
                wer_pkg::OFS_ROUTE_MISC: begin
                    if (routing_bank) begin
                        next_misc_event_to_mgmt_int_route = bus.wdata
                            & wer_pkg::ROUTE_MISC_WRITABLE;
                    end
                end
                wer_pkg::OFS_ROUTE_GP: begin
                    if (routing_bank) begin
                        next_gp_event_to_mgmt_int_route =
                            bus.wdata;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            misc_wake_event_enable <= wer_pkg::RST_REG;
            gp_wake_event_enable <= wer_pkg::RST_REG;
            wake_config_bank_select <= wer_pkg::RST_REG;
            misc_event_to_mgmt_int_route <= wer_pkg::RST_REG;
            gp_event_to_mgmt_int_route <= wer_pkg::RST_REG;
            irq_mask_misc <= wer_pkg::RST_REG;
            irq_mask_gp <= wer_pkg::RST_REG;
        end else if (ce) begin
            misc_wake_event_enable <= next_misc_wake_event_enable;
            gp_wake_event_enable <= next_gp_wake_event_enable;
            wake_config_bank_select <= next_wake_config_bank_select;
            misc_event_to_mgmt_int_route <= next_misc_event_to_mgmt_int_route;
            gp_event_to_mgmt_int_route <= next_gp_event_to_mgmt_int_route;
            irq_mask_misc <= next_irq_mask_misc;
            irq_mask_gp <= next_irq_mask_gp;
        end
    end

    // Read port; unmapped and other-bank offsets read zero
    always_comb begin
        next_rd_data = wer_pkg::RST_RDATA;
        if (bus.rd) begin
            case (bus.addr)
                wer_pkg::OFS_MISC_STATUS: next_rd_data = misc_status;
                wer_pkg::OFS_GP_STATUS: next_rd_data = gp_status;
                wer_pkg::OFS_MISC_ENABLE: next_rd_data = misc_wake_event_enable;
                wer_pkg::OFS_GP_ENABLE: next_rd_data = gp_wake_event_enable;
                wer_pkg::OFS_CONFIG: next_rd_data = wake_config_bank_select;
                wer_pkg::OFS_IRQ_MASK_MISC: next_rd_data = irq_mask_misc;
                wer_pkg::OFS_IRQ_MASK_GP: next_rd_data = irq_mask_gp;
                wer_pkg::OFS_ROUTE_MISC: begin
                    if (routing_bank) begin
                        next_rd_data = misc_event_to_mgmt_int_route;
                    end
                end
                wer_pkg::OFS_ROUTE_GP: begin
                    if (routing_bank) begin
                        next_rd_data = gp_event_to_mgmt_int_route;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Outputs and input swap
    always_comb begin
        next_wakeup_n = ~(|(misc_status & misc_wake_event_enable)
            | |(gp_status & gp_wake_event_enable));
        next_mgmt_n = ~(|(misc_status & misc_event_to_mgmt_int_route)
            | |(gp_status & gp_event_to_mgmt_int_route));
        next_irq = |(misc_status & irq_mask_misc) | |(gp_status & irq_mask_gp);
        if (wake_config_bank_select[wer_pkg::CFG_SWAP_BIT]) begin
            next_kbc_kbd = mouse_in;
            next_kbc_mouse = kbd_in;
        end else begin
            next_kbc_kbd = kbd_in;
            next_kbc_mouse = mouse_in;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= wer_pkg::RST_RDATA;
            power_wakeup_request_n <= 1'b1;
            management_interrupt_n <= 1'b1;
            irq <= 1'b0;
            kbc_kbd <= '0;
            kbc_mouse <= '0;
        end else if (ce) begin
            rd_data <= next_rd_data;
            power_wakeup_request_n <= next_wakeup_n;
            management_interrupt_n <= next_mgmt_n;
            irq <= next_irq;
            kbc_kbd <= next_kbc_kbd;
            kbc_mouse <= next_kbc_mouse;
        end
    end

    property p_soft_reset_clears;
        @(posedge clk) disable iff (!arst_n)
        ce && soft_reset |=> gp_wake_event_enable == 8'h00
            && wake_config_bank_select == 8'h00
            && misc_event_to_mgmt_int_route == 8'h00
            && gp_event_to_mgmt_int_route == 8'h00;
    endproperty
    a_soft_reset_clears: assert property (p_soft_reset_clears)
        else $error("soft reset left a register nonzero");

    property p_gp_wake_request;
        @(posedge clk) disable iff (!arst_n)
        ce && |(gp_status & gp_wake_event_enable) |=> !power_wakeup_request_n;
    endproperty
    a_gp_wake_request: assert property (p_gp_wake_request)
        else $error("enabled wake event did not request wake");

    property p_ring_shared;
        @(posedge clk) disable iff (!arst_n)
        ce && ring_select && ring_event_in |=> gp_status[4];
    endproperty
    a_ring_shared: assert property (p_ring_shared)
        else $error("ring event not captured in shared bit");

    property p_config_read;
        @(posedge clk) disable iff (!arst_n)
        ce && bus.rd && bus.addr == 8'h04 && !soft_reset
            |=> rd_data == $past(wake_config_bank_select);
    endproperty
    a_config_read: assert property (p_config_read)
        else $error("config read returned wrong value");

    property p_swap;
        @(posedge clk) disable iff (!arst_n)
        ce && wake_config_bank_select[2] |=> kbc_kbd == $past(mouse_in)
            && kbc_mouse == $past(kbd_in);
    endproperty
    a_swap: assert property (p_swap)
        else $error("keyboard and mouse inputs not swapped");

    property p_mgmt_route;
        @(posedge clk) disable iff (!arst_n)
        ce && |(gp_status & gp_event_to_mgmt_int_route)
            |=> !management_interrupt_n;
    endproperty
    a_mgmt_route: assert property (p_mgmt_route)
        else $error("routed event did not assert management interrupt");

    property p_route_bank_only;
        @(posedge clk) disable iff (!arst_n)
        ce && bus.wr && bus.addr == 8'h13 && !routing_bank && !soft_reset
            |=> $stable(misc_event_to_mgmt_int_route);
    endproperty
    a_route_bank_only: assert property (p_route_bank_only)
        else $error("routing register written outside its bank");

    property p_route_write;
        @(posedge clk) disable iff (!arst_n)
        ce && bus.wr && bus.addr == 8'h14 && routing_bank && !soft_reset
            |=> gp_event_to_mgmt_int_route == $past(bus.wdata);
    endproperty
    a_route_write: assert property (p_route_write)
        else $error("routing register write lost");

    property p_sticky_set_wins;
        @(posedge clk) disable iff (!arst_n)
        ce && |gp_set |=> (gp_status & $past(gp_set)) == $past(gp_set);
    endproperty
    a_sticky_set_wins: assert property (p_sticky_set_wins)
        else $error("detected event lost from status");

    property p_wake_idle;
        @(posedge clk) disable iff (!arst_n)
        ce && (misc_status & misc_wake_event_enable) == 8'h00
            && (gp_status & gp_wake_event_enable) == 8'h00
            |=> power_wakeup_request_n;
    endproperty
    a_wake_idle: assert property (p_wake_idle)
        else $error("wake request asserted with no enabled event");

endmodule : wer_top

`default_nettype wire

// file: wer_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module wer_host_model (
    input wire logic power_wakeup_request_n, // Wake request, active low
    input wire logic management_interrupt_n, // Mgmt interrupt, active low
    output logic wake_seen,                  // Host sees a wake request
    output logic mgmt_seen                   // Host sees a mgmt interrupt
);
    // The host only senses both lines as levels; it never drives them
    assign wake_seen = ~power_wakeup_request_n;
    assign mgmt_seen = ~management_interrupt_n;
endmodule : wer_host_model

`default_nettype wire

// file: tb_wake_event_routing.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin \
    check_count++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("wrong value at %0t: got %h exp %h", $time, g, e); \
    end \
end

module tb_wake_event_routing;
    logic clk, arst_n, ce, soft_reset, ring_event_in, ring_select;
    wer_pkg::wer_bus_req_s bus;
    wer_pkg::wer_ps2_s kbd_in, mouse_in, kbc_kbd, kbc_mouse;
    logic [7:0] rd_data, misc_event_in, gp_wake_in, exp_v, e, m;
    logic power_wakeup_request_n, management_interrupt_n, irq;
    logic wake_seen, mgmt_seen;
    logic rd_pend = 1'b0;
    logic [7:0] exp_q[$];
    logic [31:0] rng;
    int err_total, check_count;

    wer_top #(.EVENTS(8)) DUT (.clk(clk), .arst_n(arst_n), .ce(ce),
        .soft_reset(soft_reset), .bus(bus), .rd_data(rd_data),
        .misc_event_in(misc_event_in), .gp_wake_in(gp_wake_in),
        .ring_event_in(ring_event_in), .ring_select(ring_select),
        .kbd_in(kbd_in), .mouse_in(mouse_in), .kbc_kbd(kbc_kbd),
        .kbc_mouse(kbc_mouse),
        .power_wakeup_request_n(power_wakeup_request_n),
        .management_interrupt_n(management_interrupt_n), .irq(irq));

    wer_host_model u_host (.power_wakeup_request_n(power_wakeup_request_n),
        .management_interrupt_n(management_interrupt_n),
        .wake_seen(wake_seen), .mgmt_seen(mgmt_seen));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    function automatic logic [7:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng[7:0];
    endfunction : rnd

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        exp_q.push_back(x);
    endtask : rd

    task automatic idle(input int n);
        @(posedge clk);
        bus <= '0;
        gp_wake_in <= 8'h00;
        misc_event_in <= 8'h00;
        ring_event_in <= 1'b0;
        repeat (n) @(posedge clk);
    endtask : idle

    // One-cycle event pulse, then wait until the outputs have followed
    task automatic ev(input logic [7:0] g, input logic [7:0] v, input logic r);
        @(posedge clk);
        bus <= '0;
        gp_wake_in <= g;
        misc_event_in <= v;
        ring_event_in <= r;
        idle(2);
    endtask : ev

    task automatic chk_out(input logic w, input logic s, input logic q);
        @(negedge clk);
        `CHK(wake_seen, w)
        `CHK(mgmt_seen, s)
        `CHK(irq, q)
    endtask : chk_out

    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict

    // Read data stand only in the cycle after the read strobe
    always @(posedge clk) begin
        if (rd_pend) begin
            exp_v = exp_q.pop_front();
            `CHK(rd_data, exp_v)
        end
        rd_pend <= bus.rd & ce & arst_n;
    end

    initial begin
        #(3000 * 100);
        err_total++;
        print_verdict();
    end

    initial begin
        arst_n = 1'b0;
        ce = 1'b1;
        soft_reset = 1'b0;
        bus = '0;
        gp_wake_in = 8'h00;
        misc_event_in = 8'h00;
        ring_event_in = 1'b0;
        ring_select = 1'b0;
        kbd_in = '0;
        mouse_in = '0;
        rng = 32'd58;
        err_total = 0;
        check_count = 0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        chk_out(1'b0, 1'b0, 1'b0);
        rd(8'h03, 8'h00);
        rd(8'h04, 8'h00);
        wr(8'h04, 8'h02);
        rd(8'h13, 8'h00);
        rd(8'h14, 8'h00);
        for (int b = 0; b < 4; b++) begin
            wr(8'h04, 8'(b));
            wr(8'h13, (b == 2) ? 8'hFF : 8'h00);
            rd(8'h04, 8'(b));
            rd(8'h13, (b == 2) ? 8'h5F : 8'h00);
        end
        wr(8'h04, 8'hFA);
        rd(8'h04, 8'h02);
        rd(8'h13, 8'h5F);
        e = rnd();
        wr(8'h14, e);
        rd(8'h14, e);
        wr(8'h13, 8'h00);
        wr(8'h14, 8'h00);
        wr(8'h3C, 8'hFF);
        rd(8'h3C, 8'h00);
        for (int s = 0; s < 2; s++) begin
            wr(8'h04, {5'h00, s[0], 2'b10});
            idle(0);
            repeat (3) begin
                @(posedge clk);
                m = rnd();
                kbd_in <= m[1:0];
                mouse_in <= m[3:2];
                @(negedge clk);
                @(negedge clk);
                `CHK(kbc_kbd, s ? mouse_in : kbd_in)
                `CHK(kbc_mouse, s ? kbd_in : mouse_in)
            end
        end
        for (int i = 0; i < 8; i++) begin
            e = rnd();
            m = 8'h01 << i;
            wr(8'h03, e);
            ev(m, 8'h00, 1'b0);
            chk_out(e[i], 1'b0, 1'b0);
            rd(8'h01, m);
            rd(8'h01, m);
            wr(8'h01, m);
            idle(2);
            chk_out(1'b0, 1'b0, 1'b0);
        end
        @(posedge clk) ring_select <= 1'b1;
        wr(8'h03, 8'h10);
        ev(8'h10, 8'h00, 1'b0);
        chk_out(1'b0, 1'b0, 1'b0);
        ev(8'h00, 8'h00, 1'b1);
        chk_out(1'b1, 1'b0, 1'b0);
        wr(8'h01, 8'h10);
        idle(2);
        ring_select <= 1'b0;
        wr(8'h03, 8'h00);
        wr(8'h14, 8'h80);
        ev(8'h80, 8'h00, 1'b0);
        chk_out(1'b0, 1'b1, 1'b0);
        wr(8'h01, 8'h80);
        idle(2);
        chk_out(1'b0, 1'b0, 1'b0);
        wr(8'h13, 8'h04);
        wr(8'h02, 8'h08);
        ev(8'h00, 8'h2C, 1'b0);
        chk_out(1'b1, 1'b1, 1'b0);
        rd(8'h00, 8'h2C);
        wr(8'h00, 8'h08);
        idle(2);
        chk_out(1'b0, 1'b1, 1'b0);
        wr(8'h00, 8'h24);
        wr(8'h13, 8'hA0);
        ev(8'h00, 8'h20, 1'b0);
        chk_out(1'b0, 1'b0, 1'b0);
        rd(8'h13, 8'h00);
        wr(8'h00, 8'h20);
        wr(8'h06, 8'h01);
        ev(8'h01, 8'h00, 1'b0);
        chk_out(1'b0, 1'b0, 1'b1);
        wr(8'h06, 8'h00);
        idle(2);
        chk_out(1'b0, 1'b0, 1'b0);
        wr(8'h06, 8'h01);
        idle(2);
        chk_out(1'b0, 1'b0, 1'b1);
        wr(8'h01, 8'h01);
        idle(2);
        chk_out(1'b0, 1'b0, 1'b0);
        wr(8'h05, 8'h40);
        ev(8'h00, 8'h40, 1'b0);
        chk_out(1'b0, 1'b0, 1'b1);
        rd(8'h05, 8'h40);
        wr(8'h00, 8'h40);
        idle(2);
        chk_out(1'b0, 1'b0, 1'b0);
        @(posedge clk) ce <= 1'b0;
        wr(8'h03, 8'hFF);
        idle(0);
        ce <= 1'b1;
        rd(8'h03, 8'h00);
        wr(8'h03, 8'hFF);
        wr(8'h04, 8'h06);
        wr(8'h14, 8'hFF);
        idle(0);
        soft_reset <= 1'b1;
        @(posedge clk) soft_reset <= 1'b0;
        rd(8'h03, 8'h00);
        rd(8'h04, 8'h00);
        wr(8'h04, 8'h02);
        rd(8'h14, 8'h00);
        rd(8'h13, 8'h00);
        rd(8'h05, 8'h00);
        idle(3);
        print_verdict();
    end
endmodule : tb_wake_event_routing

`default_nettype wire
